// ### shared/eia_defs.svh
`ifndef EIA_DEFS_SVH
`define EIA_DEFS_SVH
// Functional notes
// (RULE1) Memory holds 512 words of 16 bits
// (RULE2) Memory reached only via pointer and data registers
// (RULE3) Set pointer first, then read or write data
// (RULE4) Data port write starts a programming cycle
// (RULE5) Programming cycle lasts 10 ms
// (RULE6) Completion sets status bit 0
// (RULE7) Host verifies only after completion flag set
// (RULE8) Host never resets during programming
// (RULE9) Host accesses memory only in standby
// (RULE10) Reset copies words 1 to 15 into registers
// (RULE11) Word 0x027 is write protected
// (RULE12) Unique ID words readable, never writable
// (RULE13) Lock word at 0x020 sets restrictions
// (RULE14) Linearization table readable and rewritable
// (RULE15) Host avoids calibration and sequence ranges; host refuses pointers only at 0x010-0x01F and from 0x100 up
// (RULE16) Address word MSB marks a write
// (RULE17) Completion flag low while programming runs
`define EIA_NV_WORDS       512
`define EIA_NV_WIDTH       16
`define EIA_NV_BLANK       16'h0000
`define EIA_FRAME_BITS     32
`define EIA_WR_BIT         15
`define EIA_REG_PTR        15'h0030
`define EIA_REG_DATA       15'h0031
`define EIA_REG_STATUS     15'h0107
`define EIA_STATUS_DONE    0
`define EIA_AD_LOCK        9'h020
`define EIA_AD_ANACAL      9'h027
`define EIA_AD_UID_LO      9'h02E
`define EIA_AD_UID_HI      9'h02F
`define EIA_AD_INIT_FIRST  9'h001
`define EIA_AD_INIT_LAST   9'h00F
`define EIA_AD_CAL_LO      9'h010
`define EIA_AD_CAL_HI      9'h01F
`define EIA_AD_ACAL_LO     9'h030
`define EIA_AD_ACAL_HI     9'h057
`define EIA_AD_LIN_LO      9'h05F
`define EIA_AD_LIN_HI      9'h07F
`define EIA_AD_SENS_LO     9'h080
`define EIA_AD_SENS_HI     9'h0FF
`define EIA_AD_SEQ_LO      9'h100
`define EIA_LK_CAL_WR      14
`define EIA_LK_CAL_RD      8
`define EIA_LK_LIN_WR      7
`define EIA_LK_SEQA_WR     6
`define EIA_LK_SEQB_WR     5
`define EIA_LK_INIT_WR     4
`define EIA_LK_MISC_RD     0
`define EIA_PROG_TIME_MS   10
`define EIA_CLK_HZ         25000000
`define EIA_PROG_CYCLES    (`EIA_PROG_TIME_MS * (`EIA_CLK_HZ / 1000))
`define EIA_HOST_HALF      8
`endif

// ### shared/eia_pkg.sv
package eia_pkg;
  typedef logic [15:0] eia_word_t;
  typedef logic [8:0]  eia_nvaddr_t;
  typedef enum logic [1:0] {S_COPY, S_IDLE, S_PROG} eia_dev_state_t;
  typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} eia_host_state_t;
endpackage

// ### shared/eia_if.sv
interface eia_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev  (input sck, input cs_n, input mosi, output miso);
  modport host (output sck, output cs_n, output mosi, input miso);
endinterface

// ### rtl/eia_dev.sv
`include "eia_defs.svh"
module eia_dev #(
  parameter int PROG_CYCLES = `EIA_PROG_CYCLES
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  // Serial link
  eia_if.dev                     link,
  // Device status
  output eia_pkg::eia_word_t     lock_word_out,
  output logic                   init_done_out,
  output logic                   prog_busy_out
);
  import eia_pkg::*;

  logic [2:0]     sck_p;
  logic [1:0]     cs_p;
  logic [1:0]     mosi_p;
  logic           rise;
  logic           fall;
  logic           act;
  logic [5:0]     cnt_r;
  logic [14:0]    rx_r;
  eia_word_t      cmd_r;
  eia_word_t      tx_r;
  logic           miso_r;
  eia_word_t      word_w;
  eia_word_t      resp;
  logic           wr_go;
  // Fresh part reads blank, so no lock bit is set before the first write
  eia_word_t      mem [`EIA_NV_WORDS] = '{default: `EIA_NV_BLANK};
  eia_word_t      vol_r [15:1];
  eia_word_t      lock_r;
  eia_nvaddr_t    ptr_r;
  eia_dev_state_t st_r;
  logic [3:0]     copy_r;
  logic [31:0]    tmr_r;
  eia_nvaddr_t    pend_a_r;
  eia_word_t      pend_d_r;
  logic           done_r;
  logic           prog_go;

  function automatic logic in_rng(eia_nvaddr_t a, eia_nvaddr_t lo, eia_nvaddr_t hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic is_cal(eia_nvaddr_t a);
    is_cal = in_rng(a, `EIA_AD_CAL_LO, `EIA_AD_CAL_HI) ||
             in_rng(a, `EIA_AD_ACAL_LO, `EIA_AD_ACAL_HI) ||
             in_rng(a, `EIA_AD_SENS_LO, `EIA_AD_SENS_HI);
  endfunction

  function automatic logic rd_ok(eia_nvaddr_t a, eia_word_t lk);
    logic bad;
    bad = lk[`EIA_LK_CAL_RD] && is_cal(a);
    bad = bad || (lk[`EIA_LK_MISC_RD] && (a >= `EIA_AD_SEQ_LO ||
          in_rng(a, `EIA_AD_LIN_LO, `EIA_AD_LIN_HI) || a <= `EIA_AD_INIT_LAST)); // RULE13
    rd_ok = !bad;
  endfunction

  function automatic logic wr_ok(eia_nvaddr_t a, eia_word_t lk);
    logic bad;
    bad = (a == `EIA_AD_ANACAL); // RULE11
    bad = bad || (a == `EIA_AD_UID_LO) || (a == `EIA_AD_UID_HI); // RULE12
    bad = bad || (lk[`EIA_LK_CAL_WR] && is_cal(a)); // RULE13
    bad = bad || (lk[`EIA_LK_LIN_WR] && in_rng(a, `EIA_AD_LIN_LO, `EIA_AD_LIN_HI)); // RULE14
    bad = bad || ((lk[`EIA_LK_SEQA_WR] || lk[`EIA_LK_SEQB_WR]) && a >= `EIA_AD_SEQ_LO);
    bad = bad || (lk[`EIA_LK_INIT_WR] && a <= `EIA_AD_INIT_LAST);
    wr_ok = !bad;
  endfunction

  // Link pins are foreign to this clock, two flops before any use
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sck_p  <= 3'h0;
      cs_p   <= 2'h3;
      mosi_p <= 2'h0;
    end else begin
      sck_p  <= {sck_p[1:0], link.sck};
      cs_p   <= {cs_p[0], link.cs_n};
      mosi_p <= {mosi_p[0], link.mosi};
    end
  end

  assign act    = !cs_p[1];
  assign rise   = act && sck_p[1] && !sck_p[2];
  assign fall   = act && !sck_p[1] && sck_p[2];
  assign word_w = {rx_r, mosi_p[1]};
  assign wr_go  = rise && (cnt_r == 6'(`EIA_FRAME_BITS - 1)) && cmd_r[`EIA_WR_BIT]; // RULE16

  // Register read view
  always_comb begin
    resp = 16'h0000;
    if (word_w[14:0] == `EIA_REG_PTR) begin
      resp = {7'h00, ptr_r};
    end else if (word_w[14:0] == `EIA_REG_DATA) begin
      resp = rd_ok(ptr_r, lock_r) ? mem[ptr_r] : 16'h0000; // RULE3
    end else if (word_w[14:0] == `EIA_REG_STATUS) begin
      resp[`EIA_STATUS_DONE] = done_r;
    end else if (word_w[14:4] == 11'h000 && word_w[3:0] != 4'h0) begin
      resp = vol_r[word_w[3:0]];
    end
  end

  // Frame shifter: address word, then data word
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r  <= 6'h00;
      rx_r   <= 15'h0000;
      cmd_r  <= 16'h0000;
      tx_r   <= 16'h0000;
      miso_r <= 1'b0;
    end else if (!act) begin
      cnt_r  <= 6'h00;
      miso_r <= 1'b0;
    end else if (rise && cnt_r < 6'(`EIA_FRAME_BITS)) begin
      rx_r  <= word_w[14:0];
      cnt_r <= cnt_r + 6'h01;
      if (cnt_r == 6'h0F) begin
        cmd_r  <= word_w;
        tx_r   <= resp;
        miso_r <= word_w[`EIA_WR_BIT] ? 1'b0 : resp[15];
      end
    end else if (fall && cnt_r > 6'h10) begin
      tx_r   <= {tx_r[14:0], 1'b0};
      miso_r <= cmd_r[`EIA_WR_BIT] ? 1'b0 : tx_r[14];
    end
  end

  assign link.miso = miso_r;

  // Address pointer register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ptr_r <= 9'h000;
    end else if (wr_go && cmd_r[14:0] == `EIA_REG_PTR) begin
      ptr_r <= word_w[8:0]; // RULE2
    end
  end

  assign prog_go = wr_go && cmd_r[14:0] == `EIA_REG_DATA && st_r == S_IDLE &&
                   wr_ok(ptr_r, lock_r); // RULE4

  // Nonvolatile array: survives reset, so no reset branch
  always_ff @(posedge clk_in) begin
    if (st_r == S_PROG && tmr_r == 32'(PROG_CYCLES - 1)) begin
      mem[pend_a_r] <= pend_d_r; // RULE1
    end
  end

  // Reset-time copy, then programming sequencer
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r     <= S_COPY;
      copy_r   <= 4'h0;
      lock_r   <= 16'h0000;
      tmr_r    <= 32'h0000_0000;
      pend_a_r <= 9'h000;
      pend_d_r <= 16'h0000;
      done_r   <= 1'b0;
    end else begin
      unique case (st_r)
        S_COPY: begin
          copy_r <= copy_r + 4'h1;
          if (copy_r == 4'h0) begin
            lock_r <= mem[`EIA_AD_LOCK]; // RULE13
          end
          if (copy_r == 4'(`EIA_AD_INIT_LAST)) begin
            st_r <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (prog_go) begin
            pend_a_r <= ptr_r;
            // Lock bits once set stay set
            pend_d_r <= (ptr_r == `EIA_AD_LOCK) ? (word_w | mem[`EIA_AD_LOCK]) : word_w;
            done_r   <= 1'b0; // RULE17
            tmr_r    <= 32'h0000_0000;
            st_r     <= S_PROG;
          end
        end
        S_PROG: begin
          tmr_r <= tmr_r + 32'h0000_0001; // RULE5
          if (tmr_r == 32'(PROG_CYCLES - 1)) begin
            done_r <= 1'b1; // RULE6
            st_r   <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Volatile register copies
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 1; i < 16; i++) begin
        vol_r[i] <= 16'h0000;
      end
    end else if (st_r == S_COPY && copy_r != 4'h0) begin
      vol_r[copy_r] <= mem[{5'h00, copy_r}]; // RULE10
    end else if (wr_go && cmd_r[14:4] == 11'h000 && cmd_r[3:0] != 4'h0) begin
      vol_r[cmd_r[3:0]] <= word_w;
    end
  end

  // Status outputs
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lock_word_out <= 16'h0000;
      init_done_out <= 1'b0;
      prog_busy_out <= 1'b0;
    end else begin
      lock_word_out <= lock_r;
      init_done_out <= (st_r != S_COPY);
      prog_busy_out <= (st_r == S_PROG);
    end
  end
endmodule

// ### rtl/eia_host.sv
`include "eia_defs.svh"
module eia_host #(
  parameter int HALF = `EIA_HOST_HALF
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  // Serial link
  eia_if.host                    link,
  // User command
  input  wire logic              req_in,
  input  wire logic              wr_in,
  input  wire logic [14:0]       addr_in,
  input  eia_pkg::eia_word_t     wdata_in,
  input  wire logic              measuring_in,
  // User answer
  output logic                   busy_out,
  output logic                   done_out,
  output logic                   err_out,
  output eia_pkg::eia_word_t     rdata_out
);
  import eia_pkg::*;

  eia_host_state_t st_r;
  logic [1:0]      miso_p;
  logic [7:0]      div_r;
  logic [4:0]      bit_r;
  logic [31:0]     sh_r;
  logic [15:0]     rx_r;
  logic            sck_r;
  logic            cs_n_r;
  logic            mosi_r;
  logic            refuse;

  // Pointer values aimed at 0x010-0x01F or at 0x100 and up are refused
  assign refuse = measuring_in || // RULE9
                  (wr_in && addr_in == `EIA_REG_PTR &&
                   ((wdata_in[8:0] >= `EIA_AD_CAL_LO && wdata_in[8:0] <= `EIA_AD_CAL_HI) ||
                    wdata_in[8:0] >= `EIA_AD_SEQ_LO)); // RULE15

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      miso_p <= 2'h0;
    end else begin
      miso_p <= {miso_p[0], link.miso};
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r      <= H_IDLE;
      div_r     <= 8'h00;
      bit_r     <= 5'h00;
      sh_r      <= 32'h0000_0000;
      rx_r      <= 16'h0000;
      sck_r     <= 1'b0;
      cs_n_r    <= 1'b1;
      mosi_r    <= 1'b0;
      busy_out  <= 1'b0;
      done_out  <= 1'b0;
      err_out   <= 1'b0;
      rdata_out <= 16'h0000;
    end else begin
      done_out <= 1'b0;
      unique case (st_r)
        H_IDLE: begin
          if (req_in && refuse) begin
            err_out  <= 1'b1;
            done_out <= 1'b1;
          end else if (req_in) begin
            err_out  <= 1'b0;
            busy_out <= 1'b1;
            cs_n_r   <= 1'b0;
            sh_r     <= {wr_in, addr_in, wdata_in}; // RULE16
            mosi_r   <= wr_in;
            bit_r    <= 5'h00;
            div_r    <= 8'h00;
            st_r     <= H_RUN;
          end
        end
        H_RUN: begin
          div_r <= div_r + 8'h01;
          // Sample late in the high phase so the slave's sync delay is covered
          if (sck_r && div_r == 8'(HALF - 2)) begin
            rx_r <= {rx_r[14:0], miso_p[1]};
          end
          if (div_r == 8'(HALF - 1)) begin
            div_r <= 8'h00;
            sck_r <= !sck_r;
            if (sck_r) begin
              bit_r  <= bit_r + 5'h01;
              sh_r   <= {sh_r[30:0], 1'b0};
              mosi_r <= sh_r[30];
              if (bit_r == 5'(`EIA_FRAME_BITS - 1)) begin
                cs_n_r <= 1'b1;
                st_r   <= H_GAP;
              end
            end
          end
        end
        H_GAP: begin
          div_r <= div_r + 8'h01;
          if (div_r == 8'(HALF - 1)) begin
            div_r     <= 8'h00;
            busy_out  <= 1'b0;
            done_out  <= 1'b1;
            rdata_out <= rx_r;
            st_r      <= H_IDLE;
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign link.sck  = sck_r;
  assign link.cs_n = cs_n_r;
  assign link.mosi = mosi_r;
endmodule

// ### verif/eia_monitor.sv
module eia_monitor #(
  parameter int PROG_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  // Status seen at the user sides
  input wire logic prog_busy_out,
  input wire logic init_done_out,
  input wire logic busy_out,
  input wire logic done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  logic        sck_r;
  logic [5:0]  nbits_r;
  logic [31:0] pcnt_r;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) sck_r <= 1'b0;
    else sck_r <= sck;
  end
  // Bits are counted per frame so a short or long frame shows up at its close
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) nbits_r <= 6'd0;
    else if (cs_n) nbits_r <= 6'd0;
    else if (sck && !sck_r) nbits_r <= nbits_r + 6'd1;
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) pcnt_r <= 32'd0;
    else if (!prog_busy_out) pcnt_r <= 32'd0;
    else pcnt_r <= pcnt_r + 32'd1;
  end

  sequence frame_end;
    $rose(cs_n);
  endsequence
  sequence release_seen;
    $rose(nrst_in);
  endsequence

  chk_prog_length: assert property ($fell(prog_busy_out) |-> pcnt_r == PROG_CYCLES)
    else $error("programming time wrong");
  chk_init_copy: assert property (release_seen |-> !init_done_out ##[14:18] init_done_out)
    else $error("init copy time wrong");
  chk_frame_bits: assert property (frame_end |-> nbits_r == 6'd32)
    else $error("frame bit count wrong");
  chk_frame_gap: assert property (frame_end |=> cs_n[*2])
    else $error("frame gap too short");
  chk_sck_idle: assert property (cs_n |-> !sck)
    else $error("clock moves outside frame");
  chk_miso_quiet: assert property (cs_n[*5] |-> !miso)
    else $error("data line busy outside frame");
  chk_mosi_hold: assert property ((sck && $past(sck)) |-> $stable(mosi))
    else $error("host data moved while clock high");
  chk_done_pulse: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  chk_frame_start: assert property ($rose(busy_out) |-> ##[0:1] !cs_n)
    else $error("busy without frame");
endmodule

// ### verif/tb_eia.sv
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_eia;
  import eia_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG = 1200;

  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        req_in = 1'b0;
  logic        wr_in = 1'b0;
  logic [14:0] addr_in = 15'h0000;
  eia_word_t   wdata_in = 16'h0000;
  logic        measuring_in = 1'b0;
  logic        busy_out, done_out, err_out, prog_busy_out, init_done_out;
  eia_word_t   rdata_out, q;
  eia_word_t   lock_word_out;
  logic        e;
  int          failures = 0;
  int          n_compared = 0;

  eia_if link();
  eia_dev #(.PROG_CYCLES(PROG)) u_eia_dev (.clk_in(clk_in), .nrst_in(nrst_in), .link(link),
    .lock_word_out(lock_word_out), .init_done_out(init_done_out),
    .prog_busy_out(prog_busy_out));
  eia_host #(.HALF(8)) u_eia_host (.clk_in(clk_in), .nrst_in(nrst_in), .link(link),
    .req_in(req_in), .wr_in(wr_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .measuring_in(measuring_in), .busy_out(busy_out), .done_out(done_out),
    .err_out(err_out), .rdata_out(rdata_out));
  eia_monitor #(.PROG_CYCLES(PROG)) u_eia_monitor (.clk_in(clk_in), .nrst_in(nrst_in),
    .sck(link.sck), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso),
    .prog_busy_out(prog_busy_out), .init_done_out(init_done_out),
    .busy_out(busy_out), .done_out(done_out));

  always #20 clk_in = ~clk_in;

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One request pulse, then a bounded wait for the done pulse
  task automatic xfer(input logic wr, input logic [14:0] a, input eia_word_t d);
    int i;
    @(posedge clk_in);
    #1;
    req_in = 1'b1;
    wr_in = wr;
    addr_in = a;
    wdata_in = d;
    @(posedge clk_in);
    #1;
    req_in = 1'b0;
    for (i = 0; i < 700 && done_out !== 1'b1; i++) begin
      @(posedge clk_in);
      #1;
    end
    if (i >= 700) begin
      failures++;
      stop_test();
    end
    q = rdata_out;
    e = err_out;
  endtask

  task automatic wr_word(input eia_nvaddr_t a, input eia_word_t d);
    xfer(1'b1, 15'h0030, {7'h00, a});
    xfer(1'b1, 15'h0031, d);
  endtask

  // Polls the status word; the flag must come back within a bounded count
  task automatic wait_prog();
    int j;
    for (j = 0; j < 10; j++) begin
      xfer(1'b0, 15'h0107, 16'h0000);
      if (q[0] === 1'b1) break;
    end
    `CHK(q[0], 1'b1)
    if (q[0] !== 1'b1) begin
      stop_test();
    end
  endtask

  task automatic do_reset();
    int k;
    nrst_in = 1'b0;
    repeat (6) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    for (k = 0; k < 100 && init_done_out !== 1'b1; k++) begin
      @(posedge clk_in);
      #1;
    end
    `CHK(init_done_out, 1'b1)
    if (init_done_out !== 1'b1) begin
      stop_test();
    end
  endtask

  eia_nvaddr_t prot [3] = '{9'h027, 9'h02E, 9'h02F};

  initial begin
    do_reset();
    xfer(1'b0, 15'h0107, 16'h0000);
    `CHK(q, 16'h0000)
    measuring_in = 1'b1;
    xfer(1'b0, 15'h0031, 16'h0000);
    `CHK(e, 1'b1)
    measuring_in = 1'b0;
    xfer(1'b1, 15'h0030, 16'h0010);
    `CHK(e, 1'b1)
    xfer(1'b1, 15'h0030, 16'h0100);
    `CHK(e, 1'b1)
    wr_word(9'h003, 16'hBEEF);
    `CHK(e, 1'b0)
    wait_prog();
    wr_word(9'h060, 16'hA5C3);
    xfer(1'b0, 15'h0107, 16'h0000);
    `CHK(q[0], 1'b0)
    // Second data write lands inside the running cycle and must be dropped
    xfer(1'b1, 15'h0031, 16'h5A5A);
    `CHK(prog_busy_out, 1'b1)
    wait_prog();
    xfer(1'b0, 15'h0031, 16'h0000);
    `CHK(q, 16'hA5C3)
    foreach (prot[n]) begin
      wr_word(prot[n], 16'h1234);
      `CHK(prog_busy_out, 1'b0)
      xfer(1'b0, 15'h0107, 16'h0000);
      `CHK(q[0], 1'b1)
    end
    xfer(1'b0, 15'h0200, 16'h0000);
    `CHK(q, 16'h0000)
    // Reset only while idle, so no cycle is cut short
    do_reset();
    xfer(1'b0, 15'h0003, 16'h0000);
    `CHK(q, 16'hBEEF)
    xfer(1'b1, 15'h0030, 16'h0060);
    xfer(1'b0, 15'h0031, 16'h0000);
    `CHK(q, 16'hA5C3)
    // Volatile copies are writable registers of their own
    xfer(1'b1, 15'h0005, 16'h0F0F);
    xfer(1'b0, 15'h0005, 16'h0000);
    `CHK(q, 16'h0F0F)
    // Lock takes effect only after the next reset copies it
    wr_word(9'h020, 16'h0080);
    wait_prog();
    do_reset();
    `CHK(lock_word_out, 16'h0080)
    wr_word(9'h060, 16'h1111);
    `CHK(prog_busy_out, 1'b0)
    xfer(1'b0, 15'h0031, 16'h0000);
    `CHK(q, 16'hA5C3)
    stop_test();
  end
endmodule
